// file: hdl/clk_ctl_pkg.sv
// package of constants and types for the pll/dll output clock controller
// assumes one 40 MHz system clock; all numbers below are shared by the top and channel files
`default_nettype none
package clk_ctl_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int NUM_OUT = 4; // pll outputs
	localparam int NUM_TAP = 8; // vco phase taps, 45 degrees apart
	localparam int NUM_LANE = 4; // memory lanes sharing one dll code
	localparam int ACC_W = 32; // vco phase accumulator
	localparam int FRAC_W = 24; // fractional feedback bits
	localparam int INT_W = 8; // integer feedback bits
	localparam int SEL_W = 3; // tap select
	localparam int RATIO_W = 7; // output divider, 1 to 127
	localparam int DLY_W = 3; // release delay, 0 to 7 quarter-rate cycles
	localparam int CODE_W = 8; // dll tap code
	localparam int PER_W = 10; // dll period counter
	localparam int QTR_W = 2; // vco cycles per quarter-rate tick, as a count width
	localparam int SHIFT_W = 3; // injection phase shift select
	localparam int SHIFT_LEN = 8; // injection phase shift stages
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_FB_INT = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_FB_FRAC = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_OUT_BASE = 8'h10; // four words, 0x10..0x1C
	localparam logic [ADDR_W-1:0] ADDR_LANE = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_FIXED = 8'h24;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_MODE = 0; // 0 time reference, 1 injection delay
	localparam int CTRL_PVT = 1; // 1 compensated fine delay
	localparam int CTRL_INJDIV_LSB = 4; // two bits
	localparam int CTRL_SHIFT_LSB = 8; // three bits
	localparam int CTRL_RUN_LSB = 16; // four bits, one per output
	localparam int OUT_SEL_LSB = 0;
	localparam int OUT_OFF = 3;
	localparam int OUT_RATIO_LSB = 4;
	localparam int OUT_DLY_LSB = 12;
	localparam int STAT_RUN_LSB = 0;
	localparam int STAT_CODE_LSB = 8;

	// ****************************************************************
	// reset values and encodings
	// ****************************************************************
	localparam logic [INT_W-1:0] RST_FB_INT = 8'h01;
	localparam logic [FRAC_W-1:0] RST_FB_FRAC = 24'h000000;
	localparam logic [RATIO_W-1:0] RST_RATIO = 7'h01;
	localparam logic [CODE_W-1:0] RST_FIXED = 8'h20;
	localparam logic [QTR_W-1:0] QTR_LAST = 2'h3;
	localparam logic [1:0] INJ_DIV1 = 2'h0;
	localparam logic [1:0] INJ_DIV2 = 2'h1;
	localparam logic [1:0] INJ_DIV4 = 2'h2;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef struct packed {
		logic off;
		logic [SEL_W-1:0] sel;
		logic [RATIO_W-1:0] ratio;
		logic [DLY_W-1:0] dly;
	} out_cfg_t;

	typedef enum logic [1:0] {CH_STOP, CH_WAIT, CH_RUN} ch_state_t;

	typedef struct packed {
		ch_state_t st;
		out_cfg_t cfg; // copy taken while stopped
		logic [RATIO_W-1:0] cnt;
		logic [DLY_W-1:0] dcnt;
		logic tap_q;
		logic out_q;
		logic run_q;
	} ch_regs_t;

endpackage : clk_ctl_pkg
`default_nettype wire

// file: hdl/clk_out_chan.sv
// one pll output channel: tap select, zero force, divider, release delay, glitch-free gate
// assumes taps and quarter tick come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module clk_out_chan (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// from the vco model
	input wire logic [clk_ctl_pkg::NUM_TAP-1:0] taps,
	input wire logic qtick,
	// control
	input wire clk_ctl_pkg::out_cfg_t cfg_in,
	input wire logic run_req,
	// output
	output logic clk_out,
	output logic running
);

	// ****************************************************************
	// state
	// ****************************************************************
	clk_ctl_pkg::ch_regs_t s_q; // all channel state
	clk_ctl_pkg::ch_regs_t s_d; // its next value
	logic tap; // selected phase
	logic rise; // rising edge of selected phase
	logic nx; // next divided level
	logic [clk_ctl_pkg::RATIO_W-1:0] half; // high part of divided period
	logic [clk_ctl_pkg::RATIO_W-1:0] cnt_n; // next edge count
	logic [clk_ctl_pkg::RATIO_W-1:0] ratio_in; // ratio with zero taken as one

	// next state
	always_comb begin
		s_d = s_q;
		tap = taps[s_q.cfg.sel];
		rise = tap & ~s_q.tap_q;
		s_d.tap_q = tap;
		// widened first so a ratio of 127 does not wrap to a zero high time
		half = 7'((8'(s_q.cfg.ratio) + 8'h01) >> 1);
		cnt_n = s_q.cnt;
		nx = 1'b0;
		ratio_in = (cfg_in.ratio == 7'h00) ? 7'h01 : cfg_in.ratio;
		unique case (s_q.st)
			clk_ctl_pkg::CH_STOP: begin
				// settings are only taken here, so a change never cuts a running pulse
				s_d.cfg = cfg_in;
				s_d.cfg.ratio = ratio_in;
				s_d.out_q = 1'b0;
				s_d.dcnt = '0;
				if (run_req && !cfg_in.off) begin
					s_d.st = clk_ctl_pkg::CH_WAIT;
				end
			end
			clk_ctl_pkg::CH_WAIT: begin
				// hold the divider until the programmed quarter-rate count passes
				s_d.out_q = 1'b0;
				if (!run_req) begin
					s_d.st = clk_ctl_pkg::CH_STOP;
				end else if (s_q.dcnt == s_q.cfg.dly && !tap) begin
					s_d.st = clk_ctl_pkg::CH_RUN;
					s_d.cnt = s_q.cfg.ratio - 7'h01;
				end else if (qtick && s_q.dcnt != s_q.cfg.dly) begin
					s_d.dcnt = s_q.dcnt + 3'h1;
				end
			end
			clk_ctl_pkg::CH_RUN: begin
				if (s_q.cfg.ratio == 7'h01) begin
					nx = tap;
				end else begin
					if (rise) begin
						cnt_n = (s_q.cnt == s_q.cfg.ratio - 7'h01) ? 7'h00 : s_q.cnt + 7'h01;
					end
					nx = (cnt_n < half);
				end
				s_d.cnt = cnt_n;
				// stop only where the next level is low, so the last pulse is whole
				if (!run_req && !nx) begin
					s_d.st = clk_ctl_pkg::CH_STOP;
					s_d.out_q = 1'b0;
				end else begin
					s_d.out_q = nx & ~s_q.cfg.off;
				end
			end
			default: begin
				s_d.st = clk_ctl_pkg::CH_STOP;
			end
		endcase
		s_d.run_q = (s_d.st == clk_ctl_pkg::CH_RUN);
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '{st: clk_ctl_pkg::CH_STOP, cfg: '0, cnt: '0, dcnt: '0,
				tap_q: 1'b0, out_q: 1'b0, run_q: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign clk_out = s_q.out_q;
	assign running = s_q.run_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_stopped_low: assert property (s_q.st != clk_ctl_pkg::CH_RUN |-> !s_q.out_q)
		else $error("stopped output not low");
	a_off_zero: assert property (s_q.cfg.off |-> ##1 !s_q.out_q [*3])
		else $error("unused output toggles");
	a_cfg_frozen: assert property ((s_q.st != clk_ctl_pkg::CH_STOP) && ($past(s_q.st) != clk_ctl_pkg::CH_STOP) |-> $stable(s_q.cfg))
		else $error("settings changed while running");
	a_div_range: assert property (s_q.st == clk_ctl_pkg::CH_RUN |-> s_q.cnt < s_q.cfg.ratio)
		else $error("divider count past ratio");
	a_wait_delay: assert property (s_q.st == clk_ctl_pkg::CH_WAIT |-> s_q.dcnt <= s_q.cfg.dly)
		else $error("release delay overrun");

endmodule : clk_out_chan
`default_nettype wire

// file: hdl/clk_ctl_top.sv
// pll/dll output clock controller: vco tap model, four output channels, dll code and modes
// assumes a register master on clk; ref_in and run_pin arrive from outside the clock domain
//
// Operation
// - vco gives eight taps, each one-eighth later
// - each output picks any tap independently
// - an unused output is held at zero
// - each output divides by 1 to 127
// - divider release delayed 0 to 7 quarter-rate cycles
// - release delay is set per output
// - feedback accepts a 24-bit fractional part
// - one vco source feeds every output
// - glitch-free start/stop from register or fabric
// - dll measures taps in a quarter period
// - lanes share code, update under own control
// - injection mode gives fixed and divided shifted outputs
`timescale 1ns/1ps
`default_nettype none
module clk_ctl_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [clk_ctl_pkg::ADDR_W-1:0] addr,
	input wire logic [clk_ctl_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [clk_ctl_pkg::DATA_W-1:0] rdata,
	// pins from fabric and reference
	input wire logic ref_in,
	input wire logic [clk_ctl_pkg::NUM_OUT-1:0] run_pin,
	// pll side
	output logic [clk_ctl_pkg::NUM_TAP-1:0] vco_taps,
	output logic [clk_ctl_pkg::NUM_OUT-1:0] pll_out,
	// dll side
	output logic [clk_ctl_pkg::CODE_W-1:0] dll_code,
	output logic [clk_ctl_pkg::NUM_LANE-1:0][clk_ctl_pkg::CODE_W-1:0] lane_code,
	output logic [clk_ctl_pkg::CODE_W-1:0] fine_code,
	output logic inj_fixed,
	output logic inj_shifted
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [clk_ctl_pkg::ACC_W-1:0] acc; // vco phase
		logic [clk_ctl_pkg::INT_W-1:0] fb_int; // feedback integer part
		logic [clk_ctl_pkg::FRAC_W-1:0] fb_frac; // feedback fraction
		logic [clk_ctl_pkg::NUM_TAP-1:0] taps;
		logic tap0_q; // edge memory for the quarter tick
		logic [clk_ctl_pkg::QTR_W-1:0] qcnt;
		logic qtick;
		logic mode; // dll mode
		logic pvt; // fine delay compensation
		logic [1:0] inj_div;
		logic [clk_ctl_pkg::SHIFT_W-1:0] shift;
		logic [clk_ctl_pkg::NUM_OUT-1:0] run_reg;
		clk_ctl_pkg::out_cfg_t [clk_ctl_pkg::NUM_OUT-1:0] cfg;
		logic [clk_ctl_pkg::NUM_LANE-1:0] lane_upd;
		logic [clk_ctl_pkg::CODE_W-1:0] fixed;
		logic [clk_ctl_pkg::NUM_OUT-1:0] run_s1; // first sync stage only
		logic [clk_ctl_pkg::NUM_OUT-1:0] run_s2;
		logic ref_s1; // first sync stage only
		logic ref_s2;
		logic ref_s3; // edge memory
		logic [clk_ctl_pkg::PER_W-1:0] per;
		logic [clk_ctl_pkg::CODE_W-1:0] code;
		logic [clk_ctl_pkg::NUM_LANE-1:0][clk_ctl_pkg::CODE_W-1:0] lane_code;
		logic [clk_ctl_pkg::CODE_W-1:0] fine;
		logic [1:0] rcnt; // reference edge count for divide by two and four
		logic [clk_ctl_pkg::SHIFT_LEN-1:0] shreg;
		logic inj_x1;
		logic inj_out;
		logic [clk_ctl_pkg::DATA_W-1:0] rdata;
	} top_regs_t;

	top_regs_t s_q; // all state
	top_regs_t s_d; // its next value
	logic [clk_ctl_pkg::NUM_OUT-1:0] chan_run; // running flags from channels
	logic [clk_ctl_pkg::SEL_W-1:0] ph; // scratch phase for tap decode
	logic ref_rise; // reference rising edge, synchronised
	logic inj_src; // divided reference before shift
	logic [2:0] hit; // output slot decode, valid and index

	// ****************************************************************
	// decoding
	// ****************************************************************
	// output word decode, used by both the write and the read path
	function automatic logic [2:0] out_slot(input logic [clk_ctl_pkg::ADDR_W-1:0] a);
		logic [clk_ctl_pkg::ADDR_W-1:0] off;
		off = a - clk_ctl_pkg::ADDR_OUT_BASE;
		out_slot = {(a >= clk_ctl_pkg::ADDR_OUT_BASE) && (off < 8'h10) && (off[1:0] == 2'h0),
			off[3:2]};
	endfunction : out_slot

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	// one process for the vco model, syncs, dll and register port
	always_comb begin
		s_d = s_q;
		ph = '0;
		inj_src = 1'b0;
		// vco model: integer plus fraction is one step; the fraction makes the rate non-integer
		s_d.acc = s_q.acc + {s_q.fb_int, s_q.fb_frac};
		// eight half-duty taps, each lagging the last by one eighth of the vco period
		for (int k = 0; k < clk_ctl_pkg::NUM_TAP; k++) begin
			ph = s_q.acc[clk_ctl_pkg::ACC_W-1 -: clk_ctl_pkg::SEL_W] - 3'(k);
			s_d.taps[k] = ~ph[clk_ctl_pkg::SEL_W-1];
		end
		// quarter-rate tick: one pulse every four vco cycles
		s_d.tap0_q = s_q.taps[0];
		s_d.qtick = 1'b0;
		if (s_q.taps[0] && !s_q.tap0_q) begin
			s_d.qcnt = s_q.qcnt + 2'h1;
			s_d.qtick = (s_q.qcnt == clk_ctl_pkg::QTR_LAST);
		end
		// pin synchronisers
		s_d.run_s1 = run_pin;
		s_d.run_s2 = s_q.run_s1;
		s_d.ref_s1 = ref_in;
		s_d.ref_s2 = s_q.ref_s1;
		s_d.ref_s3 = s_q.ref_s2;
		// dll period count, saturating so a missing reference cannot wrap the code
		if (ref_rise) begin
			s_d.per = 10'h001;
		end else if (s_q.per != '1) begin
			s_d.per = s_q.per + 10'h001;
		end
		if (!s_q.mode) begin
			// time reference: a quarter of the measured period is the 90 degree code
			if (ref_rise) begin
				s_d.code = s_q.per[clk_ctl_pkg::PER_W-1:2];
			end
			for (int i = 0; i < clk_ctl_pkg::NUM_LANE; i++) begin
				if (s_q.lane_upd[i]) begin
					s_d.lane_code[i] = s_q.code;
				end
			end
			s_d.inj_x1 = 1'b0;
			s_d.inj_out = 1'b0;
		end else begin
			// injection delay: fixed copy plus a divided, shifted copy
			if (ref_rise) begin
				s_d.rcnt = s_q.rcnt + 2'h1;
			end
			unique case (s_q.inj_div)
				clk_ctl_pkg::INJ_DIV1: inj_src = s_q.ref_s2;
				clk_ctl_pkg::INJ_DIV2: inj_src = s_q.rcnt[0];
				clk_ctl_pkg::INJ_DIV4: inj_src = s_q.rcnt[1];
				default: inj_src = s_q.ref_s2; // unused code falls back to divide by one
			endcase
			s_d.shreg = {s_q.shreg[clk_ctl_pkg::SHIFT_LEN-2:0], inj_src};
			s_d.inj_x1 = s_q.ref_s2;
			s_d.inj_out = s_q.shreg[s_q.shift];
		end
		// fine delay for a cascaded pll: measured code tracks pvt, fixed code does not
		s_d.fine = s_q.pvt ? s_q.code : s_q.fixed;
		// register writes
		if (wr) begin
			if (addr == clk_ctl_pkg::ADDR_CTRL) begin
				s_d.mode = wdata[clk_ctl_pkg::CTRL_MODE];
				s_d.pvt = wdata[clk_ctl_pkg::CTRL_PVT];
				s_d.inj_div = wdata[clk_ctl_pkg::CTRL_INJDIV_LSB +: 2];
				s_d.shift = wdata[clk_ctl_pkg::CTRL_SHIFT_LSB +: clk_ctl_pkg::SHIFT_W];
				s_d.run_reg = wdata[clk_ctl_pkg::CTRL_RUN_LSB +: clk_ctl_pkg::NUM_OUT];
			end else if (addr == clk_ctl_pkg::ADDR_FB_INT) begin
				s_d.fb_int = wdata[clk_ctl_pkg::INT_W-1:0];
			end else if (addr == clk_ctl_pkg::ADDR_FB_FRAC) begin
				s_d.fb_frac = wdata[clk_ctl_pkg::FRAC_W-1:0];
			end else if (addr == clk_ctl_pkg::ADDR_LANE) begin
				s_d.lane_upd = wdata[clk_ctl_pkg::NUM_LANE-1:0];
			end else if (addr == clk_ctl_pkg::ADDR_FIXED) begin
				s_d.fixed = wdata[clk_ctl_pkg::CODE_W-1:0];
			end else if (hit[2]) begin
				// each output keeps its own word; the channel takes it only while stopped
				s_d.cfg[hit[1:0]].sel = wdata[clk_ctl_pkg::OUT_SEL_LSB +: clk_ctl_pkg::SEL_W];
				s_d.cfg[hit[1:0]].off = wdata[clk_ctl_pkg::OUT_OFF];
				s_d.cfg[hit[1:0]].ratio = wdata[clk_ctl_pkg::OUT_RATIO_LSB +: clk_ctl_pkg::RATIO_W];
				s_d.cfg[hit[1:0]].dly = wdata[clk_ctl_pkg::OUT_DLY_LSB +: clk_ctl_pkg::DLY_W];
			end
		end
		// register reads: data in the next cycle only, unmapped reads as zero
		s_d.rdata = '0;
		if (rd) begin
			if (addr == clk_ctl_pkg::ADDR_CTRL) begin
				s_d.rdata[clk_ctl_pkg::CTRL_MODE] = s_q.mode;
				s_d.rdata[clk_ctl_pkg::CTRL_PVT] = s_q.pvt;
				s_d.rdata[clk_ctl_pkg::CTRL_INJDIV_LSB +: 2] = s_q.inj_div;
				s_d.rdata[clk_ctl_pkg::CTRL_SHIFT_LSB +: clk_ctl_pkg::SHIFT_W] = s_q.shift;
				s_d.rdata[clk_ctl_pkg::CTRL_RUN_LSB +: clk_ctl_pkg::NUM_OUT] = s_q.run_reg;
			end else if (addr == clk_ctl_pkg::ADDR_FB_INT) begin
				s_d.rdata[clk_ctl_pkg::INT_W-1:0] = s_q.fb_int;
			end else if (addr == clk_ctl_pkg::ADDR_FB_FRAC) begin
				s_d.rdata[clk_ctl_pkg::FRAC_W-1:0] = s_q.fb_frac;
			end else if (addr == clk_ctl_pkg::ADDR_STATUS) begin
				s_d.rdata[clk_ctl_pkg::STAT_RUN_LSB +: clk_ctl_pkg::NUM_OUT] = chan_run;
				s_d.rdata[clk_ctl_pkg::STAT_CODE_LSB +: clk_ctl_pkg::CODE_W] = s_q.code;
			end else if (addr == clk_ctl_pkg::ADDR_LANE) begin
				s_d.rdata[clk_ctl_pkg::NUM_LANE-1:0] = s_q.lane_upd;
			end else if (addr == clk_ctl_pkg::ADDR_FIXED) begin
				s_d.rdata[clk_ctl_pkg::CODE_W-1:0] = s_q.fixed;
			end else if (hit[2]) begin
				s_d.rdata[clk_ctl_pkg::OUT_SEL_LSB +: clk_ctl_pkg::SEL_W] = s_q.cfg[hit[1:0]].sel;
				s_d.rdata[clk_ctl_pkg::OUT_OFF] = s_q.cfg[hit[1:0]].off;
				s_d.rdata[clk_ctl_pkg::OUT_RATIO_LSB +: clk_ctl_pkg::RATIO_W] = s_q.cfg[hit[1:0]].ratio;
				s_d.rdata[clk_ctl_pkg::OUT_DLY_LSB +: clk_ctl_pkg::DLY_W] = s_q.cfg[hit[1:0]].dly;
			end
		end
	end

	// decode helpers
	assign ref_rise = s_q.ref_s2 & ~s_q.ref_s3;
	assign hit = out_slot(addr);

	// ****************************************************************
	// state register
	// ****************************************************************
	// every output word resets to ratio one, tap zero, no delay, enabled
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.fb_int <= clk_ctl_pkg::RST_FB_INT;
			s_q.fb_frac <= clk_ctl_pkg::RST_FB_FRAC;
			s_q.fixed <= clk_ctl_pkg::RST_FIXED;
			for (int i = 0; i < clk_ctl_pkg::NUM_OUT; i++) begin
				s_q.cfg[i].ratio <= clk_ctl_pkg::RST_RATIO;
			end
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// output channels
	// ****************************************************************
	// the register bit and the fabric pin each request a start
	for (genvar g = 0; g < clk_ctl_pkg::NUM_OUT; g++) begin : g_chan
		clk_out_chan u_chan (
			.clk(clk),
			.rst_n(rst_n),
			.taps(s_q.taps),
			.qtick(s_q.qtick),
			.cfg_in(s_q.cfg[g]),
			.run_req(s_q.run_reg[g] | s_q.run_s2[g]),
			.clk_out(pll_out[g]),
			.running(chan_run[g])
		);
	end

	// outputs straight from state
	assign rdata = s_q.rdata;
	assign vco_taps = s_q.taps;
	assign dll_code = s_q.code;
	assign lane_code = s_q.lane_code;
	assign fine_code = s_q.fine;
	assign inj_fixed = s_q.inj_x1;
	assign inj_shifted = s_q.inj_out;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// taps are all low for the one cycle after reset, so the count starts a cycle later
	a_tap_balance: assert property ($past(rst_n) |-> $countones(s_q.taps) == 4)
		else $error("taps not evenly spaced");
	a_code_quarter: assert property (ref_rise && !s_q.mode |=> s_q.code == $past(s_q.per[9:2]))
		else $error("dll code not a quarter period");
	a_lane_hold: assert property (s_q.lane_upd == '0 ##1 s_q.lane_upd == '0 |-> $stable(s_q.lane_code))
		else $error("lane code moved without its control");
	a_inj_idle: assert property (!s_q.mode ##1 !s_q.mode |-> !s_q.inj_x1 && !s_q.inj_out)
		else $error("injection outputs active in time reference mode");
	// fine lags the fixed word by one cycle, so the word must hold over that cycle
	a_fine_fixed: assert property (!s_q.pvt ##1 !s_q.pvt && $stable(s_q.fixed) |-> s_q.fine == s_q.fixed)
		else $error("uncompensated fine delay not fixed");
	a_read_slot: assert property (rd && addr == clk_ctl_pkg::ADDR_FB_INT |=> rdata[7:0] == $past(s_q.fb_int))
		else $error("feedback readback wrong");

endmodule : clk_ctl_top
`default_nettype wire

// file: verification/fabric_model.sv
// fabric-side model: reference clock source and the per-output run pins
// assumes the bench gives the reference half period in clk cycles and the run levels
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bench controls
	input wire logic [15:0] half_per,
	input wire logic [clk_ctl_pkg::NUM_OUT-1:0] run_req,
	// pins toward the controller
	output logic ref_in,
	output logic [clk_ctl_pkg::NUM_OUT-1:0] run_pin
);
	// ****************************************************************
	// state
	// ****************************************************************
	logic [15:0] cnt_q; // cycles since the last reference edge

	// reference is a divided clk, so its period is an exact clk count
	// run pins are registered fabric levels; the bench raises one to start an output and drops it while running to stop it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
			ref_in <= 1'b0;
			run_pin <= 4'h0;
		end else begin
			run_pin <= run_req;
			if (cnt_q >= half_per - 16'h0001) begin
				cnt_q <= 16'h0000;
				ref_in <= ~ref_in;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
endmodule : fabric_model
`default_nettype wire

// file: verification/pll_dll_output_clock_control_test.sv
// self-checking bench: registers, vco taps, output channels, dll modes
// assumes fabric_model drives the reference and run pins; one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module pll_dll_output_clock_control_test;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic clk, rst_n, wr, rd, ref_in, inj_fixed, inj_shifted;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [15:0] half_per; // reference half period in clk cycles
	logic [3:0] run_req, run_pin, pll_out;
	logic [7:0] vco_taps, dll_code, fine_code, tprv;
	logic [3:0][7:0] lane_code;
	int err_total, num_checks;
	int misph, tfix, tsh; // out1 rises off its tap phase, last injection rise cycles
	int rises[7]; // rises of pll_out 0..3, tap0, inj_fixed, inj_shifted
	int trise[8]; // last rise cycle of each tap
	int inj_exp[3] = '{20, 10, 5}; // shifted rises per div code, ref period 20

	clk_ctl_top u_clk_ctl_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .ref_in(ref_in), .run_pin(run_pin),
		.vco_taps(vco_taps), .pll_out(pll_out), .dll_code(dll_code),
		.lane_code(lane_code), .fine_code(fine_code), .inj_fixed(inj_fixed),
		.inj_shifted(inj_shifted));
	fabric_model u_fabric_model (.clk(clk), .rst_n(rst_n), .half_per(half_per),
		.run_req(run_req), .ref_in(ref_in), .run_pin(run_pin));

	// 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data are taken in the one cycle after the strobe
	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// counts over a window may be off by one at its ends
	task chk_near(input string n, input int e, input int g);
		num_checks++;
		if (g < e - 1 || g > e + 1) begin
			err_total++;
			$display("wrong value %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_near

	task chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd_reg(a, d);
		chk(n, e, d);
	endtask : chk_rd

	// sample settled outputs once a cycle and count rising edges
	task count(input int n);
		logic [6:0] prv, cur;
		#1;
		prv = {inj_shifted, inj_fixed, vco_taps[0], pll_out};
		tprv = vco_taps;
		rises = '{default: 0};
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			cur = {inj_shifted, inj_fixed, vco_taps[0], pll_out};
			for (int b = 0; b < 7; b++) if (cur[b] && !prv[b]) rises[b]++;
			for (int k = 0; k < 8; k++) if (vco_taps[k] && !tprv[k]) trise[k] = i;
			// out1 uses tap 3: it rises one cycle after the tap word shows phase 3
			if (cur[1] && !prv[1] && tprv != 8'h0F) misph++;
			if (cur[5] && !prv[5]) tfix = i;
			if (cur[6] && !prv[6]) tsh = i;
			prv = cur;
			tprv = vco_taps;
		end
	endtask : count

	task results;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results

	// the tests take about 3500 cycles; a hang is cut off well beyond that
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("watchdog expired");
		results();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
		run_req = 4'h0; half_per = 16'h0014; // reference period 40 cycles
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (200) @(posedge clk);
		chk_rd("fb_int", 8'h04, 32'h00000001);
		chk_rd("out0", 8'h10, 32'h00000010);
		chk_rd("unmapped", 8'h30, 32'h00000000);
		wr_reg(8'h0C, 32'hFFFFFFFF);
		chk_rd("status", 8'h0C, 32'h00000A00);
		wr_reg(8'h08, 32'hFFFFFFFF);
		chk_rd("fb_frac", 8'h08, 32'h00FFFFFF);
		$display("register test done");
		// step 2^24 gives a 256-cycle vco period, taps 32 cycles apart
		wr_reg(8'h08, 32'h0);
		count(300);
		for (int k = 1; k < 8; k++) chk("tap lag", 32'h20, 32'((trise[k] - trise[k-1] + 256) % 256));
		$display("tap test done");
		// dll code shared by lanes under their own enables
		wr_reg(8'h20, 32'h00000005);
		repeat (200) @(posedge clk);
		chk("dll_code", 32'h0A, 32'(dll_code));
		for (int l = 0; l < 4; l++) chk("lane_code", (l % 2) ? 32'h0 : 32'h0A, 32'(lane_code[l]));
		wr_reg(8'h24, 32'h00000033);
		// fine is registered from the stored word, one cycle behind it
		@(posedge clk);
		#1 chk("fine fixed", 32'h33, 32'(fine_code));
		wr_reg(8'h00, 32'h00000002);
		@(posedge clk);
		#1 chk("fine pvt", 32'h0A, 32'(fine_code));
		$display("dll test done");
		// injection mode, every divide code, code frozen while reference speeds up
		half_per = 16'h000A;
		for (int c = 0; c < 3; c++) begin
			wr_reg(8'h00, 32'h00000301 | (32'(c) << 4));
			count(400);
			chk_near("inj fixed", 20, rises[5]);
			chk_near("inj shifted", inj_exp[c], rises[6]);
			// divide by one with shift 3: shifted copy trails the fixed one by four cycles
			if (c == 0) chk("inj shift", 32'h4, 32'((tsh - tfix + 20) % 20));
		end
		chk("frozen code", 32'h0A, 32'(dll_code));
		wr_reg(8'h00, 32'h00000000);
		count(200);
		chk_near("fixed idle", 0, rises[5]);
		chk("dll retrack", 32'h05, 32'(dll_code));
		half_per = 16'h0014;
		$display("injection test done");
		// 16-cycle vco; outputs set up only while all are stopped
		wr_reg(8'h04, 32'h00000010);
		wr_reg(8'h10, 32'h00000010);
		wr_reg(8'h14, 32'h00000023);
		wr_reg(8'h18, 32'h00003056);
		wr_reg(8'h1C, 32'h00000018);
		repeat (200) @(posedge clk);
		wr_reg(8'h00, 32'h000B0000);
		run_req <= 4'h4;
		repeat (100) @(posedge clk);
		chk_rd("delayed start", 8'h0C, 32'h00000A03);
		repeat (200) @(posedge clk);
		chk_rd("all started", 8'h0C, 32'h00000A07);
		count(640);
		chk_near("tap0", 40, rises[4]);
		chk_near("out0 div1", 40, rises[0]);
		chk_near("out1 div2", 20, rises[1]);
		chk_near("out2 div5", 8, rises[2]);
		chk_near("out3 off", 0, rises[3]);
		chk("out1 phase", 32'h0, 32'(misph));
		wr_reg(8'h00, 32'h00000000);
		run_req <= 4'h0;
		repeat (100) @(posedge clk);
		chk_rd("stopped", 8'h0C, 32'h00000A00);
		count(100);
		for (int o = 0; o < 4; o++) chk_near("held low", 0, rises[o]);
		chk("out low", 32'h0, 32'(pll_out));
		$display("output test done");
		results();
	end
endmodule : pll_dll_output_clock_control_test
`default_nettype wire
